/* File: design/host_port_consts.vh */
// Constants for the host I/O bus and disk DMA handshake port
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// Widths
`define HP_ADDR_W 10
`define HP_DATA_W 8
// System mode encodings
`define HP_MODE_BASE 2'h0
`define HP_MODE_ALT 2'h1
`define HP_MODE_ALT_M30 2'h2
// Reset values
`define HP_ADDR_RST 10'h000
`define HP_DATA_RST 8'h00
`define HP_BASE_RST 10'h3f0
`define HP_SPAN_RST 10'h008
// Synced strobes and acknowledge idle high, qualifier low
`define HP_CTL_RST 5'h1b
// Address window field: low bits used as register index
`define HP_IDX_W 3
`endif

/* File: design/pin_sync.v */
// Two-flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pin_sync
#(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Raw and synchronised levels
  input wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // First stage feeds only the second
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync_out = sync_q;
endmodule

/* File: design/host_io_bus_dma_handshake.v */
// Host I/O bus slave port with disk DMA request, acknowledge and terminal count
// Notes on behaviour
// - Data pins stay undriven except while the port is driving read data.
// - A high DMA cycle qualifier blocks every I/O register decode.
// - All ten address bits are latched at the falling edge of either strobe.
// - The DMA request goes high while the disk core needs a byte serviced.
// - On the last byte the request drops as acknowledge falls, or as read falls if already acked.
// - While acknowledge is low the strobes go to the DMA data read or write path.
// - Terminal count counts only while acknowledge is low and then ends the transfer.
// - Terminal count is active high in base and model-30 modes, active low in alt mode.
// - Reset clears function state but leaves configuration inputs untouched.
`timescale 1ns/1ps
`include "host_port_consts.vh"
module host_io_bus_dma_handshake
(
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Host bus pins
  input wire [9:0] io_address_lines,
  input wire [7:0] host_data_lines_in,
  output wire [7:0] host_data_lines_out,
  output wire host_data_lines_oe,
  input wire io_read_strobe_n,
  input wire io_write_strobe_n,
  input wire dma_cycle_qualifier,
  // DMA handshake pins
  output wire disk_dma_request,
  input wire dma_acknowledge_n,
  input wire transfer_end_count,
  // Configuration, held outside this reset
  input wire [1:0] system_mode,
  input wire [9:0] io_base_addr,
  input wire [9:0] io_span,
  // Disk core side: register access
  output reg reg_read_pulse,
  output reg reg_write_pulse,
  output reg [9:0] reg_addr,
  output reg [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Disk core side: DMA data path
  input wire core_dma_need,
  input wire core_last_byte,
  output reg dma_read_pulse,
  output reg dma_write_pulse,
  output reg [7:0] dma_wdata,
  input wire [7:0] dma_rdata,
  output reg transfer_end_pulse
);
  wire [9:0] addr_s;
  wire [7:0] data_s;
  wire rd_n_s;
  wire wr_n_s;
  wire aen_s;
  wire ack_n_s;
  wire tc_s;
  reg rd_n_q;
  reg wr_n_q;
  reg ack_n_q;
  reg tc_act_q;
  reg [9:0] addr_q;
  reg [7:0] rdata_q;
  reg drive_q;
  reg drive_d;
  reg cycle_dma_q;
  reg cycle_hit_q;
  reg req_q;
  reg req_d;
  reg last_q;
  wire rd_fall;
  wire wr_fall;
  wire rd_rise;
  wire wr_rise;
  wire ack_fall;
  wire tc_active;
  wire hit_now;

  // Address decode, used for both strobes
  function addr_hit;
    input [9:0] a;
    input [9:0] base;
    input [9:0] span;
    reg [10:0] diff;
    begin
      diff = {1'b0, a} - {1'b0, base};
      addr_hit = !diff[10] && (diff[9:0] < span);
    end
  endfunction

  // Synchronise every pin input
  pin_sync #(.W(10), .RST_VAL(`HP_ADDR_RST)) u_addr_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(io_address_lines),
    .pin_sync_out(addr_s)
  );
  pin_sync #(.W(8), .RST_VAL(`HP_DATA_RST)) u_data_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(host_data_lines_in),
    .pin_sync_out(data_s)
  );
  pin_sync #(.W(5), .RST_VAL(`HP_CTL_RST)) u_ctl_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({io_read_strobe_n, io_write_strobe_n, dma_cycle_qualifier,
      dma_acknowledge_n, transfer_end_count}),
    .pin_sync_out({rd_n_s, wr_n_s, aen_s, ack_n_s, tc_s})
  );

  // Strobe edges
  assign rd_fall = rd_n_q && !rd_n_s;
  assign wr_fall = wr_n_q && !wr_n_s;
  assign rd_rise = !rd_n_q && rd_n_s;
  assign wr_rise = !wr_n_q && wr_n_s;
  assign ack_fall = ack_n_q && !ack_n_s;
  // Terminal count polarity by system mode
  assign tc_active = (system_mode == `HP_MODE_ALT) ? !tc_s : tc_s;
  // Decode with qualifier, at the strobe edge address
  assign hit_now = !aen_s && addr_hit(addr_s, io_base_addr, io_span);

  // Request next state
  always @*
  begin
    req_d = req_q;
    if (core_dma_need && !req_q && ack_n_s)
      req_d = 1'b1;
    if (req_q && last_q && ack_fall)
      req_d = 1'b0;
    else if (req_q && last_q && !ack_n_s && rd_fall)
      req_d = 1'b0;
    else if (req_q && !core_dma_need && ack_n_s)
      req_d = 1'b0;
  end

  // Drive enable next state
  always @*
  begin
    drive_d = drive_q;
    if (rd_fall)
      drive_d = !ack_n_s || hit_now;
    else if (rd_rise || rd_n_s)
      drive_d = 1'b0;
  end

  // Bus cycle handling; reset clears function state only
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      ack_n_q <= 1'b1;
      tc_act_q <= 1'b0;
      addr_q <= `HP_ADDR_RST;
      rdata_q <= `HP_DATA_RST;
      drive_q <= 1'b0;
      cycle_dma_q <= 1'b0;
      cycle_hit_q <= 1'b0;
      req_q <= 1'b0;
      last_q <= 1'b0;
      reg_read_pulse <= 1'b0;
      reg_write_pulse <= 1'b0;
      reg_addr <= `HP_ADDR_RST;
      reg_wdata <= `HP_DATA_RST;
      dma_read_pulse <= 1'b0;
      dma_write_pulse <= 1'b0;
      dma_wdata <= `HP_DATA_RST;
      transfer_end_pulse <= 1'b0;
    end
    else
    begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
      ack_n_q <= ack_n_s;
      tc_act_q <= tc_active && !ack_n_s;
      req_q <= req_d;
      drive_q <= drive_d;
      reg_read_pulse <= 1'b0;
      reg_write_pulse <= 1'b0;
      dma_read_pulse <= 1'b0;
      dma_write_pulse <= 1'b0;
      // Qualified terminal count ends the transfer
      transfer_end_pulse <= tc_active && !ack_n_s && !tc_act_q;
      // Core flags last byte; cleared when request drops while the core flag is low
      if (core_last_byte)
        last_q <= 1'b1;
      else if (req_q && !req_d)
        last_q <= 1'b0;
      // Latch address and route at leading edge
      if (rd_fall || wr_fall)
      begin
        addr_q <= addr_s;
        cycle_dma_q <= !ack_n_s;
        cycle_hit_q <= hit_now;
      end
      // Read: fetch data from the routed path
      if (rd_fall)
      begin
        if (!ack_n_s)
        begin
          dma_read_pulse <= 1'b1;
          rdata_q <= dma_rdata;
        end
        else if (hit_now)
        begin
          reg_read_pulse <= 1'b1;
          reg_addr <= addr_s;
          rdata_q <= reg_rdata;
        end
      end
      // Write: data is taken at the trailing edge
      if (wr_rise)
      begin
        if (cycle_dma_q)
        begin
          dma_write_pulse <= 1'b1;
          dma_wdata <= data_s;
        end
        else if (cycle_hit_q)
        begin
          reg_write_pulse <= 1'b1;
          reg_addr <= addr_q;
          reg_wdata <= data_s;
        end
      end
    end
  end

  // Pin outputs
  assign disk_dma_request = req_q;
  assign host_data_lines_out = rdata_q;
  assign host_data_lines_oe = drive_q;
endmodule

/* File: verif/host_io_bus_dma_handshake_chk.sv */
// Checker for the host bus and DMA handshake ports
`timescale 1ns/1ps
`include "host_port_consts.vh"
module host_io_bus_dma_handshake_chk
(
  // Watched ports
  input wire sys_clk,
  input wire rst,
  input wire io_read_strobe_n,
  input wire io_write_strobe_n,
  input wire dma_cycle_qualifier,
  input wire dma_acknowledge_n,
  input wire transfer_end_count,
  input wire core_last_byte,
  input wire core_dma_need,
  input wire [1:0] system_mode,
  input wire host_data_lines_oe,
  input wire disk_dma_request,
  input wire reg_read_pulse,
  input wire reg_write_pulse,
  input wire dma_read_pulse,
  input wire transfer_end_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Last byte steps of the request drop
  sequence s_ack_last;
    disk_dma_request && $fell(dma_acknowledge_n) && core_last_byte;
  endsequence
  sequence s_rd_last;
    disk_dma_request && !dma_acknowledge_n && core_last_byte && $fell(io_read_strobe_n);
  endsequence
  sequence s_drop;
    ##[1:5] !disk_dma_request;
  endsequence
  property p_oe; $rose(host_data_lines_oe) |-> $past(!io_read_strobe_n); endproperty
  a_oe: assert property (p_oe) else $error("drive without read");
  property p_qual; reg_read_pulse |-> !dma_cycle_qualifier && dma_acknowledge_n; endproperty
  a_qual: assert property (p_qual) else $error("read decoded wrongly");
  property p_wr; reg_write_pulse |-> io_write_strobe_n; endproperty
  a_wr: assert property (p_wr) else $error("write too early");
  property p_req; $rose(disk_dma_request) |-> $past(core_dma_need); endproperty
  a_req: assert property (p_req) else $error("request without need");
  property p_last; s_ack_last |-> s_drop; endproperty
  a_last: assert property (p_last) else $error("request kept at ack");
  property p_dem; s_rd_last |-> s_drop; endproperty
  a_dem: assert property (p_dem) else $error("request kept at read");
  property p_drd; dma_read_pulse |-> !dma_acknowledge_n; endproperty
  a_drd: assert property (p_drd) else $error("dma read without ack");
  property p_tcq; transfer_end_pulse |-> !dma_acknowledge_n; endproperty
  a_tcq: assert property (p_tcq) else $error("count without ack");
  property p_tcp;
    transfer_end_pulse |-> transfer_end_count == (system_mode != `HP_MODE_ALT);
  endproperty
  a_tcp: assert property (p_tcp) else $error("count polarity");
endmodule
bind host_io_bus_dma_handshake host_io_bus_dma_handshake_chk chk (.*);

/* File: verif/dma_ctl_model.sv */
// System DMA controller model answering the disk request
`timescale 1ns/1ps
module dma_ctl_model
(
  // Clock and handshake
  input wire sys_clk,
  input wire grant_en,
  input wire disk_dma_request,
  output reg dma_acknowledge_n
);
  // Acknowledge a pending request, release when disabled
  initial dma_acknowledge_n = 1'b1;
  always @(posedge sys_clk)
    if (!grant_en)
      dma_acknowledge_n <= 1'b1;
    else if (disk_dma_request)
      dma_acknowledge_n <= 1'b0;
endmodule

/* File: verif/host_io_bus_dma_handshake_test.sv */
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module host_io_bus_dma_handshake_test;
  logic sys_clk, rst, rd_n, wr_n, qual, need, last, tc, en;
  logic [9:0] addr;
  logic [7:0] wd, rdat, seen_d;
  logic [1:0] mode;
  wire oe, req, ack_n, rp, wp, dr, dw, te;
  wire [9:0] ra;
  wire [7:0] rw, dwd, dout, hin;
  int n_errors = 0, n_compared = 0, c_rp = 0, c_wp = 0, c_dr = 0, c_te = 0, c_dw = 0;
  assign hin = oe ? dout : wd;
  host_io_bus_dma_handshake uut
  (
    .sys_clk(sys_clk), .rst(rst), .io_address_lines(addr), .host_data_lines_in(hin),
    .host_data_lines_out(dout), .host_data_lines_oe(oe), .io_read_strobe_n(rd_n),
    .io_write_strobe_n(wr_n), .dma_cycle_qualifier(qual), .disk_dma_request(req),
    .dma_acknowledge_n(ack_n), .transfer_end_count(tc), .system_mode(mode),
    .io_base_addr(10'h3f0), .io_span(10'h008), .reg_read_pulse(rp), .reg_write_pulse(wp),
    .reg_addr(ra), .reg_wdata(rw), .reg_rdata(rdat), .core_dma_need(need),
    .core_last_byte(last), .dma_read_pulse(dr), .dma_write_pulse(dw), .dma_wdata(dwd),
    .dma_rdata(8'h3c), .transfer_end_pulse(te)
  );
  dma_ctl_model dma (.sys_clk(sys_clk), .grant_en(en), .disk_dma_request(req),
    .dma_acknowledge_n(ack_n));
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Count core side pulses, keep driven read data
  always @(posedge sys_clk)
  begin
    c_rp <= c_rp + rp;
    c_wp <= c_wp + wp;
    c_dr <= c_dr + dr;
    c_dw <= c_dw + dw;
    c_te <= c_te + te;
    if (oe)
      seen_d <= dout;
  end
  task automatic chk(input logic [9:0] s, input logic [9:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task w8;
    repeat (8) @(posedge sys_clk);
  endtask
  // One strobe cycle, address moved while the strobe is low
  task automatic cyc(input logic w, input logic [9:0] a);
    addr <= a;
    @(posedge sys_clk);
    {rd_n, wr_n} <= w ? 2'h2 : 2'h1;
    repeat (4) @(posedge sys_clk);
    addr <= ~a;
    repeat (4) @(posedge sys_clk);
    {rd_n, wr_n} <= 2'h3;
    w8;
  endtask
  task t_reg;
    chk(oe, 0);
    chk(req, 0);
    cyc(0, 10'h3f1);
    chk(10'(c_rp), 1);
    chk(ra, 10'h3f1);
    chk(seen_d, 8'h5a);
    chk(oe, 0);
    wd <= 8'ha5;
    cyc(1, 10'h3f2);
    chk(10'(c_wp), 1);
    chk(rw, 8'ha5);
    chk(ra, 10'h3f2);
    rdat <= 8'h11;
    qual <= 1'b1;
    cyc(0, 10'h3f1);
    qual <= 1'b0;
    cyc(0, 10'h200);
    chk(10'(c_rp), 1);
    chk(seen_d, 8'h5a);
    $display("t_reg done");
  endtask
  task t_dma;
    {need, en} <= 2'h3;
    w8;
    chk(req, 1);
    last <= 1'b1;
    cyc(0, 10'h3f1);
    chk(10'(c_dr), 1);
    chk(10'(c_rp), 1);
    chk(req, 0);
    chk(seen_d, 8'h3c);
    wd <= 8'h69;
    cyc(1, 10'h3f2);
    chk(10'(c_dw), 1);
    chk(dwd, 8'h69);
    chk(10'(c_wp), 1);
    en <= 1'b0;
    w8;
    chk(req, 1);
    en <= 1'b1;
    w8;
    chk(req, 0);
    {need, last, en} <= 3'h0;
    w8;
    $display("t_dma done");
  endtask
  task t_tc;
    for (int m = 0; m < 3; m++)
    begin
      mode <= 2'(m);
      tc <= (m == 1);
      w8;
      tc <= (m != 1);
      w8;
      chk(10'(c_te), 10'(m));
      tc <= (m == 1);
      {need, en} <= 2'h3;
      w8;
      tc <= (m != 1);
      w8;
      tc <= (m == 1);
      w8;
      {need, en} <= 2'h0;
      w8;
      chk(10'(c_te), 10'(m + 1));
    end
    $display("t_tc done");
  endtask
  // Reset in mid-run with a request pending
  task t_rst;
    {need, en} <= 2'h3;
    w8;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(req, 0);
    chk(ra, 10'h000);
    chk(oe, 0);
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    w8;
    chk(req, 1);
    {need, en} <= 2'h0;
    w8;
    $display("t_rst done");
  endtask
  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    {rst, rd_n, wr_n, qual, need, last, tc, en} = 8'he0;
    {mode, addr, wd, rdat} = 28'h000005a;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    w8;
    t_reg;
    t_dma;
    t_tc;
    t_rst;
    report_and_stop;
  end
endmodule
